// ===== fault_injection_recovery.sv
// Fault injection, propagation and recovery sequencer for a load point converter.
// Assumes open-drain group and system lines with external pull-ups, pins asynchronous
// to clk, and an AXI4-Lite master with 32-bit data.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

// Notes on behaviour
// R1: Injected faults take exactly the same shutdown and recovery path as real ones.
// R2: Faults pull group or system line low as the propagation setting asks.
// R3: Injected trigger stays active while the inject bit is set, clears on withdrawal.
// R4: Non-latching fault restarts after 130 ms hiccup once trigger clears.
// R5: Latching fault keeps output off after trigger clears until explicit clear.
// R6: Latched fault clears by enable pin toggle or off then on command.
// R7: Manager turns group on when bus power present and converters configured.
// R8: Manager polls voltage, current and temperature of groups with polling enabled.
// R9: Converter samples voltage, current and temperature every cycle regardless of polling.
// R10: Manager reads status registers only for groups with status polling enabled.
// R11: Manager always notices a low group power-good line.
// R12: Auto-on and polling options are per group and touch only the manager.
// R13: Group fault shuts every member down; groups without cross propagation keep running.
// R14: Shared sync/data line carries switching sync and manager communication; here its falling edges are used only as switching sync.
// R15: Hiccup timer starts on trigger release and restarts if fault reasserts.
module fault_injection_recovery import fault_recovery_pkg::*; #(
    parameter int HICCUP_CYCLES = HICCUP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter pins
    input wire logic en_pin,
    input wire logic [NFT-1:0] fault_pin,
    input wire logic sync_data_line,
    output logic out_en,
    output logic sw_sync,
    // Group power-good line, open drain
    input wire logic grp_line_i,
    output logic grp_line_o,
    output logic grp_line_oe,
    // System shutdown line, open drain
    input wire logic sys_line_i,
    output logic sys_line_o,
    output logic sys_line_oe,
    // Measurement samples, same clock
    input wire logic [11:0] adc_vout,
    input wire logic [7:0] adc_iout,
    input wire logic [7:0] adc_temp
);

    typedef struct packed {
        pwr_state_type st;
        logic out_en;
        logic on_cmd;
        logic [NFT-1:0] latch_cfg;
        logic [2*NFT-1:0] prop;
        logic [NFT-1:0] inject;
        logic [NFT-1:0] latched;
        logic [NFT-1:0] log;
        logic grp_oe;
        logic sys_oe;
        logic sw_sync;
        logic sdl_prev;
        logic [11:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;

    logic [NFT+3:0] pins_s;
    logic en_s;
    logic [NFT-1:0] flt_s;
    logic sdl_s;
    logic grp_low;
    logic sys_low;
    logic [NFT-1:0] trig;
    logic [NFT-1:0] own_lat;
    logic grp_ext;
    logic sys_ext;
    logic any_stop;
    logic enable;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [31:0] status_word;

    hiccup_if hif ();

    // All pins share one synchroniser bank; active-high pins enter inverted so the all-ones reset reads idle
    pin_sync3 #(.W(NFT + 4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din({sys_line_i, grp_line_i, sync_data_line, ~fault_pin, ~en_pin}),
        .dout(pins_s)
    );

    hiccup_timer #(.CYC(HICCUP_CYCLES)) u_hiccup (
        .clk(clk),
        .rst_b(rst_b),
        .hif(hif)
    );

    // Pin decode; lines are active low when pulled
    assign en_s = !pins_s[0];
    assign flt_s = ~pins_s[NFT:1];
    assign sdl_s = pins_s[NFT+1];
    assign grp_low = !pins_s[NFT+2];
    assign sys_low = !pins_s[NFT+3];

    // Real and injected triggers merge so both follow one path
    assign trig = flt_s | s_q.inject; // R1 R3
    assign own_lat = trig & s_q.latch_cfg;
    // Our own pull must not read back as a neighbour's fault
    assign grp_ext = grp_low && !s_q.grp_oe; // R13
    assign sys_ext = sys_low && !s_q.sys_oe;
    assign any_stop = (|trig) || grp_ext || sys_ext;
    assign enable = en_s && s_q.on_cmd;
    // Timer only runs once every stop cause has gone
    assign hif.run = (s_q.st == ST_HICCUP) && !any_stop; // R15

    // Status word built from live state
    always_comb begin
        status_word = '0;
        status_word[ST_STATE_LSB +: 2] = s_q.st;
        status_word[ST_OUT_BIT] = s_q.out_en;
        status_word[ST_TRIG_LSB +: NFT] = trig;
        status_word[ST_LATCH_LSB +: NFT] = s_q.latched;
        status_word[ST_GRP_BIT] = grp_low;
        status_word[ST_SYS_BIT] = sys_low;
    end

    // Read decode; unmapped offsets answer with an error
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_word[CTRL_ON_BIT] = s_q.on_cmd;
            OFS_LATCH_CFG: rd_word[NFT-1:0] = s_q.latch_cfg;
            OFS_PROP_CFG: rd_word[2*NFT-1:0] = s_q.prop;
            OFS_INJECT: rd_word[NFT-1:0] = s_q.inject;
            OFS_STATUS: rd_word = status_word;
            OFS_FAULT_LOG: rd_word[NFT-1:0] = s_q.log;
            OFS_TELEM: rd_word = {4'h0, s_q.temp, s_q.iout, s_q.vout};
            default: rd_ok = 1'b0;
        endcase
    end

    // Next-state logic for sequencer, lines and register file
    always_comb begin
        s_d = s_q;

        // Measurements follow the converter at all times
        s_d.vout = adc_vout; // R9
        s_d.iout = adc_iout; // R9
        s_d.temp = adc_temp; // R9

        // Switching sync taken from falling edges of the shared line
        s_d.sdl_prev = sdl_s;
        s_d.sw_sync = s_q.sdl_prev && !sdl_s; // R14

        // Power sequencer
        unique case (s_q.st)
            ST_OFF: begin
                s_d.latched = '0;
                if (enable && !any_stop) begin
                    s_d.st = ST_ON;
                end
            end
            ST_ON: begin
                if (!enable) begin
                    s_d.st = ST_OFF;
                end else if (|own_lat) begin
                    s_d.st = ST_LATCHED; // R5
                    s_d.latched = own_lat;
                end else if (any_stop) begin
                    s_d.st = ST_HICCUP; // R1 R13
                end
            end
            ST_HICCUP: begin
                if (!enable) begin
                    s_d.st = ST_OFF;
                end else if (|own_lat) begin
                    s_d.st = ST_LATCHED;
                    s_d.latched = own_lat;
                end else if (hif.expired) begin
                    s_d.st = ST_ON; // R4
                end
            end
            ST_LATCHED: begin
                // Trigger release alone never leaves here
                s_d.latched = s_q.latched | own_lat; // R5
                if (!enable) begin
                    s_d.st = ST_OFF; // R6
                end
            end
        endcase
        s_d.out_en = (s_d.st == ST_ON);

        // Propagation: live or latched faults hold the lines low
        s_d.grp_oe = |((trig | s_d.latched) & s_q.prop[NFT-1:0]); // R2 R13
        s_d.sys_oe = |((trig | s_d.latched) & s_q.prop[PROP_SYS_LSB +: NFT]); // R2

        // Sticky fault log; a new fault beats a same-cycle clear
        s_d.log = s_q.log | trig;

        // Write address and data are taken independently
        if (s_q.awready && s_axi_awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Commit once both halves are held; all fields live in byte lane 0
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            unique case (s_q.awaddr)
                OFS_CTRL: if (s_q.wstrb[0]) s_d.on_cmd = s_q.wdata[CTRL_ON_BIT]; // R6
                OFS_LATCH_CFG: if (s_q.wstrb[0]) s_d.latch_cfg = s_q.wdata[NFT-1:0];
                OFS_PROP_CFG: if (s_q.wstrb[0]) s_d.prop = s_q.wdata[2*NFT-1:0];
                OFS_INJECT: if (s_q.wstrb[0]) s_d.inject = s_q.wdata[NFT-1:0]; // R3
                OFS_FAULT_LOG: if (s_q.wstrb[0]) s_d.log = (s_q.log & ~s_q.wdata[NFT-1:0]) | trig;
                OFS_STATUS, OFS_TELEM: ;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;

        // Single outstanding read, answered the next cycle
        if (s_q.arready && s_axi_arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = !s_d.rvalid;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.st <= ST_OFF;
            s_q.on_cmd <= CTRL_ON_RST;
            s_q.latch_cfg <= LATCH_CFG_RST;
            s_q.prop <= PROP_CFG_RST;
            s_q.inject <= INJECT_RST;
            s_q.sdl_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops; open-drain data is always low
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign out_en = s_q.out_en;
    assign sw_sync = s_q.sw_sync;
    assign grp_line_o = 1'b0;
    assign grp_line_oe = s_q.grp_oe;
    assign sys_line_o = 1'b0;
    assign sys_line_oe = s_q.sys_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_inject_trip;
        (s_q.st == ST_ON) && enable && (|s_q.inject) |=> (s_q.st != ST_ON) ##0 !out_en;
    endproperty
    a_inject_trip: assert property (p_inject_trip) else $error("injected fault ignored"); // R1

    property p_grp_pull;
        |(trig & s_q.prop[NFT-1:0]) |=> grp_line_oe;
    endproperty
    a_grp_pull: assert property (p_grp_pull) else $error("group line not pulled"); // R2

    property p_inject_held;
        (s_q.inject[FT_OVER_TEMP] && (s_q.st == ST_HICCUP)) [*3] |-> !hif.run;
    endproperty
    a_inject_held: assert property (p_inject_held) else $error("trigger dropped while injected"); // R3

    property p_hiccup_wait;
        (s_q.st == ST_HICCUP) && !hif.expired |=> !out_en;
    endproperty
    a_hiccup_wait: assert property (p_hiccup_wait) else $error("restart before hiccup end"); // R4

    property p_latch_stay;
        (s_q.st == ST_LATCHED) && enable |=> (s_q.st == ST_LATCHED) && !out_en;
    endproperty
    a_latch_stay: assert property (p_latch_stay) else $error("latched fault left without clear"); // R5

    property p_latch_clear;
        (s_q.st == ST_LATCHED) && !enable |=> (s_q.st == ST_OFF) ##1 (s_q.latched == '0);
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latched fault not cleared"); // R6

    property p_telem;
        1'b1 |=> (s_q.vout == $past(adc_vout)) && (s_q.temp == $past(adc_temp));
    endproperty
    a_telem: assert property (p_telem) else $error("measurement not sampled"); // R9

    property p_grp_member;
        (s_q.st == ST_ON) && enable && grp_ext |=> !out_en;
    endproperty
    a_grp_member: assert property (p_grp_member) else $error("member kept running"); // R13

    property p_sync_edge;
        $fell(sdl_s) |=> sw_sync ##1 !sw_sync;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("sync pulse missing"); // R14

    property p_hic_restart;
        (s_q.st == ST_HICCUP) && any_stop |=> !hif.expired;
    endproperty
    a_hic_restart: assert property (p_hic_restart) else $error("hiccup ran during fault"); // R15

    c_hiccup_restart: cover property ((s_q.st == ST_HICCUP) ##1 (s_q.st == ST_ON));
    c_latched_off: cover property ((s_q.st == ST_LATCHED) ##1 (s_q.st == ST_OFF));
    c_write_done: cover property (s_q.bvalid && s_axi_bready);

endmodule : fault_injection_recovery

// ===== fault_injection_recovery_tb.sv
// Self-checking bench for the fault injection and recovery sequencer.
// Assumes the manager model drives the sync and open-drain lines; hiccup shortened to 20 cycles.
`timescale 1ns/1ns
module fault_injection_recovery_tb import fault_recovery_pkg::*;;
    localparam int HCYC = 20;
    typedef struct {logic [7:0] a; logic wr; logic [31:0] wd; logic [31:0] ed; logic [1:0] er;} row_type;
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, fault_pin;
    logic [27:0] adc;
    logic [1:0] bresp, rresp;
    logic en_pin, sync_line, out_en, sw_sync, grp_line, grp_oe, sys_line, sys_oe, pull_grp;
    int n_mismatch, comparisons, low_seen;
    row_type rows [9];

    fault_injection_recovery #(.HICCUP_CYCLES(HCYC)) u_fault_injection_recovery (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .en_pin(en_pin), .fault_pin(fault_pin),
        .sync_data_line(sync_line), .out_en(out_en), .sw_sync(sw_sync), .grp_line_i(grp_line),
        .grp_line_o(), .grp_line_oe(grp_oe), .sys_line_i(sys_line), .sys_line_o(), .sys_line_oe(sys_oe),
        .adc_vout(adc[11:0]), .adc_iout(adc[19:12]), .adc_temp(adc[27:20]));

    power_manager_model u_power_manager_model (
        .clk(clk), .rst_b(rst_b), .grp_oe(grp_oe), .sys_oe(sys_oe), .pull_grp(pull_grp),
        .sync_data_line(sync_line), .grp_line(grp_line), .sys_line(sys_line), .low_seen(low_seen));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic timeout();
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        close_out();
    endtask : timeout

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // Address and data offered together; bready raised early so the answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask : rd

    // Cycles until the power stage enable reaches the wanted level
    task automatic wait_out(input logic lvl, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (out_en === lvl) return;
        end
        timeout();
    endtask : wait_out

    // Main sequence: register table, then fault and recovery cases
    initial begin
        int n;
        int c;
        logic [1:0] r;
        logic [31:0] d;
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready, en_pin, pull_grp} = '0;
        {awaddr, araddr, wdata, wstrb, fault_pin} = '0;
        adc = 28'h3e5dabc;
        rows = '{'{8'h00, 0, 0, 0, RESP_OKAY}, '{8'h04, 0, 0, 0, RESP_OKAY}, '{8'h08, 0, 0, 32'h0f, RESP_OKAY},
            '{8'h0c, 0, 0, 0, RESP_OKAY}, '{8'h10, 1, 32'hff, 0, RESP_OKAY},
            '{8'h18, 0, 0, 32'h03e5dabc, RESP_OKAY}, '{8'h04, 1, 32'h5, 32'h5, RESP_OKAY},
            '{8'h04, 1, 0, 0, RESP_OKAY}, '{8'h1c, 1, 32'h1, 0, RESP_SLVERR}};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].wd, r);
            if (rows[i].wr) chk(r, rows[i].er, "bresp");
            rd(rows[i].a, d, r);
            chk(r, rows[i].er, "rresp");
            if (r === RESP_OKAY) chk(d, rows[i].ed, "rdata");
        end
        c = 0;
        repeat (80) begin
            @(posedge clk);
            if (sw_sync === 1'b1) c++;
        end
        chk(c >= 9 && c <= 11, 1'b1, "sync pulses");
        en_pin <= 1'b1;
        wr(OFS_CTRL, 32'h1, r);
        wait_out(1'b1, 20, n);
        rd(OFS_STATUS, d, r);
        chk(d[7:0], 8'h05, "status on");
        // Every fault type injected, group mask set for it, system mask for another
        for (int i = 0; i < NFT; i++) begin
            wr(OFS_PROP_CFG, (32'h1 << i) | (32'h10 << ((i + 1) % NFT)), r);
            wr(OFS_INJECT, 32'h1 << i, r);
            wait_out(1'b0, 20, n);
            repeat (3) @(posedge clk);
            chk(grp_oe, 1'b1, "group pull");
            chk(sys_oe, 1'b0, "system quiet");
            rd(OFS_STATUS, d, r);
            chk(d[7:0], 8'h02 | (8'h10 << i), "status hiccup");
            repeat (40) @(posedge clk);
            chk(out_en, 1'b0, "held off");
            wr(OFS_INJECT, 32'h0, r);
            wait_out(1'b1, HCYC + 12, n);
        end
        rd(OFS_FAULT_LOG, d, r);
        chk(d, 32'hf, "log sticky");
        wr(OFS_FAULT_LOG, 32'hf, r);
        rd(OFS_FAULT_LOG, d, r);
        chk(d, 32'h0, "log cleared");
        chk(low_seen > 0, 1'b1, "low line seen");
        // Fault returning mid-hiccup must restart the wait
        wr(OFS_PROP_CFG, 32'h0f, r);
        wr(OFS_INJECT, 32'h1, r);
        wait_out(1'b0, 20, n);
        wr(OFS_INJECT, 32'h0, r);
        repeat (HCYC / 2) @(posedge clk);
        wr(OFS_INJECT, 32'h1, r);
        wr(OFS_INJECT, 32'h0, r);
        wait_out(1'b1, HCYC + 12, n);
        chk(n >= HCYC - 4, 1'b1, "hiccup length");
        // Real latching fault, cleared by the enable pin
        wr(OFS_LATCH_CFG, 32'h8, r);
        fault_pin <= 4'h8;
        wait_out(1'b0, 20, n);
        fault_pin <= 4'h0;
        repeat (HCYC * 3) @(posedge clk);
        chk(out_en, 1'b0, "latched off");
        rd(OFS_STATUS, d, r);
        chk(d[1:0], 2'h3, "latched state");
        en_pin <= 1'b0;
        repeat (8) @(posedge clk);
        en_pin <= 1'b1;
        wait_out(1'b1, 20, n);
        // Injected latching fault, cleared by off then on
        wr(OFS_INJECT, 32'h8, r);
        wait_out(1'b0, 20, n);
        wr(OFS_INJECT, 32'h0, r);
        repeat (HCYC * 2) @(posedge clk);
        chk(out_en, 1'b0, "injected latch");
        wr(OFS_CTRL, 32'h0, r);
        wr(OFS_CTRL, 32'h1, r);
        wait_out(1'b1, 20, n);
        // Foreign group fault shuts this member down without its own pull
        pull_grp <= 1'b1;
        wait_out(1'b0, 20, n);
        chk(grp_oe, 1'b0, "no own pull");
        pull_grp <= 1'b0;
        wait_out(1'b1, HCYC + 16, n);
        adc <= 28'h1234567;
        repeat (3) @(posedge clk);
        rd(OFS_TELEM, d, r);
        chk(d, 32'h01234567, "telem follows");
        // Mid-run reset restores defaults
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        chk(out_en, 1'b0, "reset off");
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFS_CTRL, d, r);
        chk(d, 32'h0, "reset on cmd");
        close_out();
    end
endmodule : fault_injection_recovery_tb

// ===== fault_recovery_pkg.sv
// Constants, offsets and types shared by the fault recovery block.
// Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register bus.
package fault_recovery_pkg;

    // Clock and hiccup timing
    localparam int CLK_HZ = 100_000_000;
    localparam int HICCUP_MS = 130;
    localparam int HICCUP_CYC = HICCUP_MS * (CLK_HZ / 1000);
    localparam int HIC_W = 24;

    // Fault types, one bit each
    localparam int NFT = 4;
    localparam int FT_OVER_VOLT = 0;
    localparam int FT_UNDER_VOLT = 1;
    localparam int FT_OVER_CURR = 2;
    localparam int FT_OVER_TEMP = 3;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LATCH_CFG = 8'h04;
    localparam logic [7:0] OFS_PROP_CFG = 8'h08;
    localparam logic [7:0] OFS_INJECT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FAULT_LOG = 8'h14;
    localparam logic [7:0] OFS_TELEM = 8'h18;

    // Field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int PROP_SYS_LSB = 4;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_OUT_BIT = 2;
    localparam int ST_TRIG_LSB = 4;
    localparam int ST_LATCH_LSB = 8;
    localparam int ST_GRP_BIT = 12;
    localparam int ST_SYS_BIT = 13;
    localparam int TEL_IOUT_LSB = 12;
    localparam int TEL_TEMP_LSB = 20;

    // Reset values
    localparam logic CTRL_ON_RST = 1'h0;
    localparam logic [3:0] LATCH_CFG_RST = 4'h0;
    localparam logic [7:0] PROP_CFG_RST = 8'h0f;
    localparam logic [3:0] INJECT_RST = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Converter power state
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_HICCUP, ST_LATCHED} pwr_state_type;

endpackage : fault_recovery_pkg

// ===== hiccup_if.sv
// Link between the recovery sequencer and its hiccup timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface hiccup_if;
    logic run;
    logic expired;
    modport ctrl (output run, input expired);
    modport timer (input run, output expired);
endinterface : hiccup_if

// ===== hiccup_timer.sv
// Hiccup delay counter for non-latching fault restart.
// Assumes run is held high for the whole wait; dropping it restarts the count.
`timescale 1ns/1ns
module hiccup_timer import fault_recovery_pkg::*; #(
    parameter int CYC = HICCUP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sequencer link
    hiccup_if.timer hif
);

    typedef struct packed {
        logic [HIC_W-1:0] cnt;
        logic expired;
    } hic_state_type;

    hic_state_type s_q;
    hic_state_type s_d;

    // Count while run holds; any drop clears the count
    always_comb begin
        s_d = s_q;
        if (!hif.run) begin
            s_d.cnt = '0; // R15
            s_d.expired = 1'b0;
        end else if (s_q.cnt == HIC_W'(CYC - 1)) begin
            s_d.expired = 1'b1; // R4
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hif.expired = s_q.expired;

    property p_hic_reset;
        @(posedge clk) disable iff (!rst_b) !hif.run |=> (s_q.cnt == '0) && !hif.expired;
    endproperty
    a_hic_reset: assert property (p_hic_reset) else $error("hiccup count not cleared"); // R15

    property p_hic_len;
        @(posedge clk) disable iff (!rst_b) $rose(hif.expired) |-> s_q.cnt == HIC_W'(CYC - 1);
    endproperty
    a_hic_len: assert property (p_hic_len) else $error("hiccup expired early"); // R4

endmodule : hiccup_timer

// ===== pin_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync3 import fault_recovery_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Raw and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_type;

    sync_state_type s_q;
    sync_state_type s_d;

    // Per-bit chain; first stage feeds only the second
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_comb begin
                s_d.s1[i] = din[i];
                s_d.s2[i] = s_q.s1[i];
                s_d.s3[i] = s_q.s2[i];
                s_d.q[i] = (s_q.s2[i] == s_q.s3[i]) ? s_q.s3[i] : s_q.q[i];
            end
        end
    endgenerate

    // Reset to released-line level (all ones) so idle open-drain lines read high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.q;

endmodule : pin_sync3

// ===== power_manager_model.sv
// Manager stand-in: switching sync source and pulled-up group and system lines.
// Assumes the device only drives output enables on the open-drain lines.
`timescale 1ns/1ns
module power_manager_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Device enables and bench request for a foreign group fault
    input wire logic grp_oe,
    input wire logic sys_oe,
    input wire logic pull_grp,
    // Lines seen by the device, and the low group line count for the bench
    output logic sync_data_line,
    output logic grp_line,
    output logic sys_line,
    output int low_seen
);
    logic [2:0] div_q;
    logic grp_q;

    // Free-running sync, one falling edge every 8 cycles; switching pauses only while reset holds the divider at zero
    always_ff @(posedge clk) begin
        div_q <= rst_b ? div_q + 3'h1 : 3'h0;
    end
    assign sync_data_line = div_q[2];

    // Pull-ups hold the lines high unless someone pulls low
    assign grp_line = ~(grp_oe | pull_grp);
    assign sys_line = ~sys_oe;

    // A low group line is always noticed, polling or not
    always_ff @(posedge clk) begin
        grp_q <= grp_line;
        if (!rst_b) begin
            low_seen <= 0;
        end else if (grp_q && !grp_line) begin
            low_seen <= low_seen + 1;
        end
    end
endmodule : power_manager_model
